// ===== hw/ciaf_defs.vh
// Constants for the interrupt acceptance flag block
`ifndef CIAF_DEFS_VH
`define CIAF_DEFS_VH

// Register offsets
`define CIAF_OFS_FLAGS   4'h0
`define CIAF_OFS_STATUS  4'h1
`define CIAF_OFS_HSP     4'h2
`define CIAF_OFS_TSP     4'h3

// Flag word field positions
`define CIAF_BIT_MASK    0
`define CIAF_BIT_SSEL    1
`define CIAF_BIT_RSVD    7
`define CIAF_PRI_LSB     12
`define CIAF_PRI_MSB     14

// Reset values
`define CIAF_FLAGS_RST   16'h0000
`define CIAF_SP_RST      16'h0000

// Field widths and limits
`define CIAF_PRI_W       3
`define CIAF_TRAP_LAST   6'h1f

`endif

// ===== hw/ciaf_flags.v
// Interrupt acceptance flags: mask gate, stack select, priority level
//
// Notes on behaviour
// - Mask gate at 0 blocks maskable requests; at 1 they are considered.
// - Any acknowledged interrupt clears the mask gate to 0.
// - Stack select 0 picks handler stack pointer, 1 picks task stack pointer.
// - Hardware acknowledge or software trap 0..31 clears stack select.
// - Priority level field is three bits, levels 0 through 7.
// - Request accepted only when its priority exceeds current level.
// - Low reset input forces the reset state.
`timescale 1ns/100ps
`include "ciaf_defs.vh"

module ciaf_flags (
  input  wire        clk,          // CPU clock, 50 MHz
  input  wire        rst_n,        // Asynchronous reset, active low
  input  wire [3:0]  reg_addr,     // Register address
  input  wire [15:0] reg_wdata,    // Register write data
  input  wire        reg_wr,       // Write strobe
  input  wire        reg_rd,       // Read strobe
  output reg  [15:0] reg_rdata,    // Read data, one cycle after strobe
  input  wire        irq_req,      // Maskable request pending
  input  wire [2:0]  irq_pri,      // Priority of pending request
  output wire        irq_take,     // Request may be taken now
  input  wire        ack_hw,       // Hardware interrupt acknowledged, pulse
  input  wire        ack_sw,       // Software trap executed, pulse
  input  wire [5:0]  trap_num,     // Trap number beside ack_sw
  input  wire        sp_ld,        // Load selected stack pointer
  input  wire [15:0] sp_din,       // New stack pointer value
  output wire [15:0] sp_active,    // Currently selected stack pointer
  output reg         mask_gate,    // Mask gate flag
  output reg         stack_sel,    // Stack select flag
  output reg  [2:0]  cpu_priority_level // Processor priority level
);

  reg [15:0] handler_stack_pointer;
  reg [15:0] task_stack_pointer;

  // ***************************************************
  // Helpers
  // ***************************************************

  // Strict priority compare
  function pri_wins;
    input [2:0] req;
    input [2:0] cur;
    begin
      pri_wins = (req > cur);
    end
  endfunction

  // Assembles the flag word; reserved bit reads zero
  function [15:0] flag_word;
    input       m;
    input       s;
    input [2:0] p;
    begin
      flag_word = 16'h0000;
      flag_word[`CIAF_BIT_MASK] = m;
      flag_word[`CIAF_BIT_SSEL] = s;
      flag_word[`CIAF_PRI_MSB:`CIAF_PRI_LSB] = p;
    end
  endfunction

  // ***************************************************
  // Acceptance decision
  // ***************************************************

  assign irq_take = irq_req & mask_gate & pri_wins(irq_pri, cpu_priority_level);

  // ***************************************************
  // Flag register
  // ***************************************************

  // Address match against one register offset
  function addr_hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Write strobe decode per register
  wire       flags_wr;
  wire       hsp_wr;
  wire       tsp_wr;
  wire       trap_low;
  wire       any_ack;
  wire       sel_clear;

  assign flags_wr  = reg_wr && addr_hit(reg_addr, `CIAF_OFS_FLAGS);
  assign hsp_wr    = reg_wr && addr_hit(reg_addr, `CIAF_OFS_HSP);
  assign tsp_wr    = reg_wr && addr_hit(reg_addr, `CIAF_OFS_TSP);
  // Only low-numbered traps touch the stack select
  assign trap_low  = ack_sw && (trap_num <= `CIAF_TRAP_LAST);
  assign any_ack   = ack_hw || ack_sw;
  assign sel_clear = ack_hw || trap_low;

  // Next flag values
  reg        next_mask_gate;
  reg        next_stack_sel;
  reg  [2:0] next_cpu_priority_level;

  // Sequencer acknowledges win over a same-cycle software write
  always @* begin
    next_mask_gate          = mask_gate;
    next_stack_sel          = stack_sel;
    next_cpu_priority_level = cpu_priority_level;
    if (flags_wr) begin
      next_mask_gate          = reg_wdata[`CIAF_BIT_MASK];
      next_stack_sel          = reg_wdata[`CIAF_BIT_SSEL];
      next_cpu_priority_level = reg_wdata[`CIAF_PRI_MSB:`CIAF_PRI_LSB];
    end
    if (any_ack) begin
      next_mask_gate = 1'b0;
    end
    if (sel_clear) begin
      next_stack_sel = 1'b0;
    end
  end

  // Flag flops
  // reset state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_gate          <= 1'b0;
      stack_sel          <= 1'b0;
      cpu_priority_level <= 3'h0;
    end else begin
      mask_gate          <= next_mask_gate;
      stack_sel          <= next_stack_sel;
      cpu_priority_level <= next_cpu_priority_level;
    end
  end

  // ***************************************************
  // Stack pointers
  // ***************************************************

  assign sp_active = stack_sel ? task_stack_pointer : handler_stack_pointer;

  // Next pointer values
  reg [15:0] next_handler_stack_pointer;
  reg [15:0] next_task_stack_pointer;

  // Software write wins over a sequencer load
  always @* begin
    next_handler_stack_pointer = handler_stack_pointer;
    next_task_stack_pointer    = task_stack_pointer;
    if (hsp_wr) begin
      next_handler_stack_pointer = reg_wdata;
    end else if (sp_ld && !stack_sel) begin
      next_handler_stack_pointer = sp_din;
    end
    if (tsp_wr) begin
      next_task_stack_pointer = reg_wdata;
    end else if (sp_ld && stack_sel) begin
      next_task_stack_pointer = sp_din;
    end
  end

  // Pointer flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      handler_stack_pointer <= `CIAF_SP_RST;
      task_stack_pointer    <= `CIAF_SP_RST;
    end else begin
      handler_stack_pointer <= next_handler_stack_pointer;
      task_stack_pointer    <= next_task_stack_pointer;
    end
  end

  // ***************************************************
  // Read port
  // ***************************************************

  // Read data valid only the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CIAF_OFS_FLAGS:  reg_rdata <= flag_word(mask_gate, stack_sel, cpu_priority_level);
        `CIAF_OFS_STATUS: reg_rdata <= {12'h000, irq_take, irq_pri};
        `CIAF_OFS_HSP:    reg_rdata <= handler_stack_pointer;
        `CIAF_OFS_TSP:    reg_rdata <= task_stack_pointer;
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ===== verif/ciaf_src.sv
// Far-side request source with acknowledge
`timescale 1ns/100ps
module ciaf_src (
  input  wire       clk,         // clock
  input  wire       go,          // raise request
  input  wire [2:0] pri,         // its level
  input  wire       take,        // grant
  output reg        req = 1'h0,  // request
  output reg  [2:0] rpri = 3'h0, // level out
  output reg        ack = 1'h0   // ack pulse
);
  // One ack per grant; idle level toggles
  always @(posedge clk) begin
    req <= go;
    rpri <= go ? pri : ~rpri;
    ack <= take & ~ack;
  end
endmodule

// ===== verif/ciaf_flags_chk.sv
// Assertions on the flag block
`timescale 1ns/100ps
module ciaf_chk (
  input wire       clk,               // clock
  input wire       rst_n,             // reset
  input wire       irq_req,           // req
  input wire [2:0] irq_pri,           // pri
  input wire       irq_take,          // take
  input wire       ack_hw,            // ack
  input wire       ack_sw,            // trap
  input wire [5:0] trap_num,          // num
  input wire       mask_gate,         // gate
  input wire       stack_sel,         // sel
  input wire [2:0] cpu_priority_level // lvl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_mask_blocks: assert property (!mask_gate |-> !irq_take) else $error("masked");
  a_take_level: assert property (irq_take |-> irq_pri > cpu_priority_level) else $error("low");
  a_take_req: assert property (irq_take |-> irq_req) else $error("no req");
  a_win_take: assert property (mask_gate && irq_req && irq_pri > cpu_priority_level |-> irq_take)
    else $error("miss");
  a_ack_mask: assert property (ack_hw || ack_sw |=> !mask_gate) else $error("gate");
  a_hw_sel: assert property (ack_hw |=> !stack_sel) else $error("hw sel");
  a_trap_sel: assert property (ack_sw && trap_num < 6'h20 |=> !stack_sel) else $error("trap");
  a_reset_state: assert property (disable iff (1'h0) !rst_n |-> {mask_gate,stack_sel,cpu_priority_level} == 5'h0)
    else $error("reset");
endmodule
bind ciaf_flags ciaf_chk ciaf_chk_inst (.*);

// ===== verif/testbench.sv
// Bench for the flag block
`timescale 1ns/100ps
module testbench;
  reg         clk = 0, rst_n = 1, reg_wr = 0, reg_rd = 0, ack_sw = 0, sp_ld = 0, go = 0;
  reg  [15:0] reg_wdata = 0, sp_din = 0;
  reg  [5:0]  trap_num = 0;
  reg  [3:0]  reg_addr = 0;
  reg  [2:0]  pri = 0;
  wire [15:0] reg_rdata, sp_active;
  wire [2:0]  irq_pri, cpu_priority_level;
  wire        irq_req, irq_take, ack_hw, mask_gate, stack_sel;
  integer     bad_count = 0, checks_done = 0, cyc = 0, i;
  always #10 clk = ~clk;
  ciaf_flags ciaf_flags_inst (.*);
  ciaf_src ciaf_src_inst (.clk(clk), .go(go), .pri(pri), .take(irq_take), .req(irq_req), .rpri(irq_pri), .ack(ack_hw));
  task chk(input string n, input [15:0] e, g);
    checks_done++;
    if (e !== g) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end
  endtask
  task wr(input [15:0] d);
    @(posedge clk); reg_wr <= 1; reg_addr <= 4'h0; reg_wdata <= d;
    @(posedge clk); reg_wr <= 0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk); reg_rd <= 1; reg_addr <= a;
    @(posedge clk); reg_rd <= 0; #1 chk("rd", e, reg_rdata);
  endtask
  task t_prio;
    for (i = 0; i < 8; i++) begin
      wr(16'h3003); go <= 1; pri <= i[2:0];
      @(posedge clk); #1 chk("take", i > 3, irq_take);
      repeat (2) @(posedge clk); #1 chk("gate", i < 4, mask_gate);
      chk("sel", i < 4, stack_sel); go <= 0;
    end
    wr(16'h0002); go <= 1; pri <= 3'h7;
    @(posedge clk); #1 chk("take", 16'h0, irq_take);
    rd(4'h1, 16'h0007); go <= 0;
  endtask
  task t_trap;
    for (i = 0; i < 4; i++) begin
      wr(16'h0003); ack_sw <= 1; trap_num <= {i[1], {5{i[0]}}};
      @(posedge clk); ack_sw <= 0; #1 chk("sel", i[1], stack_sel);
      chk("gate", 16'h0, mask_gate);
    end
  endtask
  task t_sp;
    wr(16'h0000); sp_ld <= 1; sp_din <= 16'h1234;
    @(posedge clk); sp_ld <= 0; #1 chk("sp", 16'h1234, sp_active);
    wr(16'h0002); #1 chk("sp", 16'h0000, sp_active);
    rd(4'h0, 16'h0002); rd(4'h2, 16'h1234); rd(4'hf, 16'h0000);
  endtask
  task t_rst;
    wr(16'h7003); rd(4'h0, 16'h7003);
    rst_n <= 0;
    repeat (2) @(posedge clk); #1 chk("flags", 16'h0, {mask_gate, stack_sel, cpu_priority_level});
    rst_n <= 1;
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) if (++cyc == 3000) begin bad_count++; test_done; end
  // Main sequence
  initial begin
    rst_n <= 0;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    t_prio; t_trap; t_sp; t_rst; test_done;
  end
endmodule
